//--- rtl/pioc_pkg.sv
// Shared constants and types of the configurable I/O block.
// Assumes a single 25 MHz reference clock and a 32-bit Avalon-MM register bus.
package pioc_pkg;

	// Clock rate and ramp step time
	localparam int CLK_HZ        = 25_000_000;
	localparam int SLEW_STEP_NS  = 10_000;
	localparam int SLEW_STEP_CYC = (SLEW_STEP_NS * (CLK_HZ / 1_000_000)) / 1000;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_BUCK1  = 8'h08;
	localparam logic [7:0] OFS_BUCK2  = 8'h0C;
	localparam logic [7:0] OFS_SLEW   = 8'h10;
	localparam logic [7:0] OFS_RSTCNT = 8'h14;
	localparam logic [7:0] OFS_NOW1   = 8'h18;
	localparam logic [7:0] OFS_NOW2   = 8'h1C;

	// Control register fields
	localparam int CTRL_PA_LVL  = 0;
	localparam int CTRL_PB_LVL  = 1;
	localparam int CTRL_PC_LVL  = 2;
	localparam int CTRL_PB_PP   = 3;
	localparam int CTRL_MRS     = 4;
	localparam int CTRL_CRR_EN  = 5;
	localparam int CTRL_PA_SEQ  = 6;
	localparam int CTRL_PC_SEQ  = 7;

	// Status register fields
	localparam int ST_PA    = 0;
	localparam int ST_PC    = 1;
	localparam int ST_PG    = 2;
	localparam int ST_PB    = 3;
	localparam int ST_RAMP  = 4;
	localparam int ST_CSEEN = 5;

	// Reset values
	localparam logic [7:0] CTRL_RST  = 8'h07;
	localparam logic [5:0] BUCK1_DEF = 6'h10;
	localparam logic [5:0] BUCK2_DEF = 6'h14;
	localparam logic [2:0] SLEW_RST  = 3'h0;

	// Input synchroniser lanes
	localparam int         SYNC_N   = 3;
	localparam int         SYNC_A   = 0;
	localparam int         SYNC_C   = 1;
	localparam int         SYNC_PG  = 2;
	localparam logic [2:0] SYNC_RST = 3'h3;

	// Bus answer sequence
	typedef enum logic {BUS_IDLE, BUS_ANSWER} pioc_bus_e;

endpackage

//--- rtl/pioc_sync_if.sv
// Carries raw pin levels into the synchroniser and filtered levels back out.
// Assumes the top module drives raw and reads level and fall.
`timescale 1ns/100ps
interface pioc_sync_if;
	logic [2:0] raw;
	logic [2:0] level;
	logic [2:0] fall;

	modport drv (output raw, input level, input fall);
	modport syn (input raw, output level, output fall);
endinterface

//--- rtl/pioc_sync.sv
// Three-stage synchroniser with agreement filter and falling-edge pulse.
// Assumes asynchronous pin inputs and a synchronous active-low reset.
`timescale 1ns/100ps
module pioc_sync
(
	input  wire logic     i_ref_clk,
	input  wire logic     i_rst_n,
	pioc_sync_if.syn      sif
);

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] level;
		logic [2:0] fall;
	} pioc_sync_state_s;

	pioc_sync_state_s s_r;
	pioc_sync_state_s s_nxt;

	// Stage one feeds only stage two; the filter looks at stages two and three
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.s1 = sif.raw;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		for (int b = 0; b < pioc_pkg::SYNC_N; b++)
		begin
			if (s_r.s2[b] == s_r.s3[b])
				s_nxt.level[b] = s_r.s2[b];
			s_nxt.fall[b] = s_r.level[b] & ~s_nxt.level[b]; // R11
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			s_r       <= '0;
			s_r.s1    <= pioc_pkg::SYNC_RST;
			s_r.s2    <= pioc_pkg::SYNC_RST;
			s_r.s3    <= pioc_pkg::SYNC_RST;
			s_r.level <= pioc_pkg::SYNC_RST;
		end
		else
			s_r <= s_nxt;
	end

	// Outputs come straight from flip-flops, one pulse per filtered fall
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_out
			assign sif.level[g] = s_r.level[g];
			assign sif.fall[g]  = s_r.fall[g];
		end
	endgenerate

endmodule // pioc_sync

//--- rtl/pioc_ddr_io.sv
// Configurable I/O logic: memory-reset pass/latch pin pair and core rail reset pin.
// Assumes a 25 MHz clock, synchronous active-low power-on reset, and an
// Avalon-MM master that holds its request until waitrequest is low.
//
// Overview of operation
// R1: Pin A open-drain from level bit when mode clear
// R2: Pin A level from user bit or sequencer
// R3: Mode set, power good: pin B follows A
// R4: Power good low: B low after reset, else latched
// R5: Mode clear, drive type 0: B open-drain
// R6: Mode clear, drive type 1: B push-pull
// R7: Mode set: B ignores user bit, keeps buffer
// R8: Reset enable clear: pin C open-drain output
// R9: Pin C fall restores both core voltage registers
// R10: Core rails ramp back at slew rate
// R11: Pins and power good synchronised before edges
// R12: Host idles pin C high, falls only to reset
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module pioc_ddr_io
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	// Avalon-MM slave
	input  wire logic [7:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	// Memory-reset input / open-drain output
	input  wire logic        i_pin_a,
	output logic             o_pin_a,
	output logic             o_pin_a_oe,
	// Memory-reset output
	output logic             o_pin_b,
	output logic             o_pin_b_oe,
	// Core rail reset input / open-drain output
	input  wire logic        i_pin_c,
	output logic             o_pin_c,
	output logic             o_pin_c_oe,
	// Power sequencer side
	input  wire logic        i_power_good,
	input  wire logic        i_seq_pin_a_level,
	input  wire logic        i_seq_pin_c_level,
	// Core buck converter set points as applied, and the core rail reset pulse
	output logic      [5:0]  o_buck_one_vsel,
	output logic      [5:0]  o_buck_two_vsel,
	output logic             o_core_rail_reset
);

	typedef struct packed {
		pioc_pkg::pioc_bus_e bus;
		logic [31:0]         rdata;
		logic [7:0]          ctrl;
		logic [1:0][5:0]     tgt;
		logic [1:0][5:0]     now;
		logic [2:0]          slew;
		logic [15:0]         step_cnt;
		logic [7:0]          rst_cnt;
		logic                c_seen;
		logic                pin_b_hold;
		logic                pa_out;
		logic                pa_oe;
		logic                pb_out;
		logic                pb_oe;
		logic                pc_out;
		logic                pc_oe;
		logic                rail_rst;
	} pioc_top_state_s;

	pioc_top_state_s s_r;
	pioc_top_state_s s_nxt;

	pioc_sync_if u_sif ();

	// Pins and power good come from outside the clock domain; every use below
	// reads only the filtered levels, never the raw pins, so a slow edge cannot
	// be seen twice or split between two decisions in one cycle
	// Raw pins into the synchroniser lanes
	assign u_sif.raw[pioc_pkg::SYNC_A]  = i_pin_a;
	assign u_sif.raw[pioc_pkg::SYNC_C]  = i_pin_c;
	assign u_sif.raw[pioc_pkg::SYNC_PG] = i_power_good;

	pioc_sync u_sync
	(
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.sif       (u_sif.syn)
	);

	logic a_sync;
	logic c_sync;
	logic pg_sync;
	logic c_fall;

	// Filtered levels and the pin C falling-edge pulse
	assign a_sync  = u_sif.level[pioc_pkg::SYNC_A];
	assign c_sync  = u_sif.level[pioc_pkg::SYNC_C];
	assign pg_sync = u_sif.level[pioc_pkg::SYNC_PG];
	assign c_fall  = u_sif.fall[pioc_pkg::SYNC_C]; // R11

	// Whole next state: bus slave, pin drivers, rail reset and ramp
	always_comb
	begin
		logic [31:0] rd_word;
		logic [15:0] period;
		logic        mrs;
		logic        a_lvl;
		logic        b_lvl;
		logic        c_lvl;
		logic        wr_go;
		rd_word = 32'h00000000;
		period  = 16'h0000;
		mrs     = 1'b0;
		a_lvl   = 1'b0;
		b_lvl   = 1'b0;
		c_lvl   = 1'b0;
		wr_go   = 1'b0;
		s_nxt   = s_r;
		s_nxt.rail_rst = 1'b0;

		// Register map, one 32-bit word each, low bits only:
		//   control - user levels of pins A, B, C; B push-pull; memory-reset mode;
		//             rail reset enable; sequencer source for pins A and C
		//   status  - filtered pins A, C and power good; driven B level;
		//             ramp in progress; pin C reset seen (write 1 to clear)
		//   targets - core rail set points, restored by a pin C fall
		//   slew    - step period is the base step shifted left by this field
		//   count   - accepted pin C resets, wraps
		//   applied - codes now driven to the two core rails, read only
		// Read multiplexer; unmapped offsets read as zero
		case (i_address)
			pioc_pkg::OFS_CTRL:   rd_word = {24'h000000, s_r.ctrl};
			pioc_pkg::OFS_STATUS:
			begin
				rd_word[pioc_pkg::ST_PA]    = a_sync;
				rd_word[pioc_pkg::ST_PC]    = c_sync;
				rd_word[pioc_pkg::ST_PG]    = pg_sync;
				rd_word[pioc_pkg::ST_PB]    = s_r.pb_oe ? s_r.pb_out : 1'b1;
				rd_word[pioc_pkg::ST_RAMP]  = (s_r.now != s_r.tgt);
				rd_word[pioc_pkg::ST_CSEEN] = s_r.c_seen;
			end
			pioc_pkg::OFS_BUCK1:  rd_word = {26'h0000000, s_r.tgt[0]};
			pioc_pkg::OFS_BUCK2:  rd_word = {26'h0000000, s_r.tgt[1]};
			pioc_pkg::OFS_SLEW:   rd_word = {29'h0000000, s_r.slew};
			pioc_pkg::OFS_RSTCNT: rd_word = {24'h000000, s_r.rst_cnt};
			pioc_pkg::OFS_NOW1:   rd_word = {26'h0000000, s_r.now[0]};
			pioc_pkg::OFS_NOW2:   rd_word = {26'h0000000, s_r.now[1]};
			default:              rd_word = 32'h00000000;
		endcase

		// One wait cycle: data is captured on the first edge, handed over on the second
		case (s_r.bus)
			pioc_pkg::BUS_IDLE:
			begin
				if (i_read || i_write)
				begin
					s_nxt.bus   = pioc_pkg::BUS_ANSWER;
					s_nxt.rdata = i_read ? rd_word : 32'h00000000;
				end
			end
			pioc_pkg::BUS_ANSWER:
			begin
				s_nxt.bus = pioc_pkg::BUS_IDLE;
				wr_go     = i_write & i_byteenable[0];
			end
			default:
				s_nxt.bus = pioc_pkg::BUS_IDLE;
		endcase

		// Register writes; only the low byte lane carries bits
		if (wr_go)
		begin
			case (i_address)
				pioc_pkg::OFS_CTRL:   s_nxt.ctrl   = i_writedata[7:0];
				pioc_pkg::OFS_BUCK1:  s_nxt.tgt[0] = i_writedata[5:0];
				pioc_pkg::OFS_BUCK2:  s_nxt.tgt[1] = i_writedata[5:0];
				pioc_pkg::OFS_SLEW:   s_nxt.slew   = i_writedata[2:0];
				pioc_pkg::OFS_STATUS:
				begin
					if (i_writedata[pioc_pkg::ST_CSEEN])
						s_nxt.c_seen = 1'b0;
				end
				default:
					s_nxt.ctrl = s_r.ctrl;
			endcase
		end

		mrs = s_r.ctrl[pioc_pkg::CTRL_MRS];

		// Pin A: sequencer or user bit sets the open-drain level
		a_lvl = s_r.ctrl[pioc_pkg::CTRL_PA_SEQ] ? i_seq_pin_a_level
		                                        : s_r.ctrl[pioc_pkg::CTRL_PA_LVL]; // R2
		if (!mrs)
		begin
			s_nxt.pa_out = 1'b0;   // R1
			s_nxt.pa_oe  = ~a_lvl; // R1
		end
		else
		begin
			s_nxt.pa_out = 1'b0;
			s_nxt.pa_oe  = 1'b0;   // R3
		end

		// Memory-reset copy: follows pin A while power is good in memory-reset mode, freezes when it drops,
		// so the held value is the level seen at the falling edge of power good
		if (mrs && pg_sync)
			s_nxt.pin_b_hold = a_sync; // R3 R4

		// Pin B level source
		b_lvl = mrs ? s_nxt.pin_b_hold : s_r.ctrl[pioc_pkg::CTRL_PB_LVL]; // R7

		// Pin B buffer type applies in both modes; in open-drain use the board
		// pull-up sets the high level, so a released pin is only as fast as that
		// pull-up allows
		// Pin B buffer type applies in both modes
		if (s_r.ctrl[pioc_pkg::CTRL_PB_PP])
		begin
			s_nxt.pb_out = b_lvl;  // R6 R7
			s_nxt.pb_oe  = 1'b1;   // R6
		end
		else
		begin
			s_nxt.pb_out = 1'b0;   // R5 R7
			s_nxt.pb_oe  = ~b_lvl; // R5
		end

		// Pin C: open-drain output unless it is the rail reset input
		c_lvl = s_r.ctrl[pioc_pkg::CTRL_PC_SEQ] ? i_seq_pin_c_level
		                                        : s_r.ctrl[pioc_pkg::CTRL_PC_LVL];
		if (!s_r.ctrl[pioc_pkg::CTRL_CRR_EN])
		begin
			s_nxt.pc_out = 1'b0;   // R8
			s_nxt.pc_oe  = ~c_lvl; // R8
		end
		else
		begin
			s_nxt.pc_out = 1'b0;
			s_nxt.pc_oe  = 1'b0;
		end

		// Ramp the applied codes one step per tick toward their targets;
		// the rails are never switched off, only walked back
		period = 16'(pioc_pkg::SLEW_STEP_CYC) << s_r.slew;
		if (s_r.step_cnt == 16'h0000)
		begin
			s_nxt.step_cnt = period - 16'h0001;
			for (int i = 0; i < 2; i++)
			begin
				if (s_r.now[i] < s_r.tgt[i])
					s_nxt.now[i] = s_r.now[i] + 6'h01; // R10
				else if (s_r.now[i] > s_r.tgt[i])
					s_nxt.now[i] = s_r.now[i] - 6'h01; // R10
			end
		end
		else
			s_nxt.step_cnt = s_r.step_cnt - 16'h0001;

		// A pin C fall restores only the two core targets; it beats a same-cycle
		// software write so a host reset is never lost, and it sets the seen flag
		// over any clear in that cycle
		if (s_r.ctrl[pioc_pkg::CTRL_CRR_EN] && c_fall)
		begin
			s_nxt.tgt[0]   = pioc_pkg::BUCK1_DEF;   // R9
			s_nxt.tgt[1]   = pioc_pkg::BUCK2_DEF;   // R9
			s_nxt.rail_rst = 1'b1;
			s_nxt.c_seen   = 1'b1;
			s_nxt.rst_cnt  = s_r.rst_cnt + 8'h01;
		end
	end

	// Reset leaves the memory-reset copy low, so once memory-reset mode is set the memory is held in reset
	// until the host has driven pin A high while power is good
	// State register; control returns to its defaults on power-on reset
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			s_r            <= '0;
			s_r.bus        <= pioc_pkg::BUS_IDLE;
			s_r.ctrl       <= pioc_pkg::CTRL_RST;
			s_r.tgt[0]     <= pioc_pkg::BUCK1_DEF;
			s_r.tgt[1]     <= pioc_pkg::BUCK2_DEF;
			s_r.now[0]     <= pioc_pkg::BUCK1_DEF;
			s_r.now[1]     <= pioc_pkg::BUCK2_DEF;
			s_r.slew       <= pioc_pkg::SLEW_RST;
			s_r.pin_b_hold <= 1'b0; // R4
		end
		else
			s_r <= s_nxt;
	end

	// Combinational so the master sees the wait in the very cycle it asks;
	// every request costs exactly one wait cycle, reads and writes alike
	// Waitrequest is released only in the answer cycle
	assign o_waitrequest = (i_read | i_write) & (s_r.bus != pioc_pkg::BUS_ANSWER);
	assign o_readdata    = s_r.rdata;

	// Pin and rail outputs, all from flip-flops
	assign o_pin_a           = s_r.pa_out;
	assign o_pin_a_oe        = s_r.pa_oe;
	assign o_pin_b           = s_r.pb_out;
	assign o_pin_b_oe        = s_r.pb_oe;
	assign o_pin_c           = s_r.pc_out;
	assign o_pin_c_oe        = s_r.pc_oe;
	assign o_buck_one_vsel   = s_r.now[0];
	assign o_buck_two_vsel   = s_r.now[1];
	assign o_core_rail_reset = s_r.rail_rst;

endmodule // pioc_ddr_io

//--- bench/pioc_host_model.sv
// Host reset logic and pull-ups on the two shared open-drain pins.
// Assumes the bench sets host levels and the block reports its pull-down enables.
`timescale 1ns/100ps
module pioc_host_model
(
	input  wire logic i_host_a,
	input  wire logic i_host_c,
	input  wire logic i_pin_a_oe,
	input  wire logic i_pin_c_oe,
	output logic      o_pin_a,
	output logic      o_pin_c
);
	// Wired-AND with pull-up: a released line floats high, never keeps the last value
	assign o_pin_a = i_host_a & ~i_pin_a_oe;
	assign o_pin_c = i_host_c & ~i_pin_c_oe;
endmodule // pioc_host_model

//--- bench/pioc_ddr_io_sva.sv
// Port-level checker of the configurable I/O block.
// Assumes one reference clock and a synchronous active-low reset.
`timescale 1ns/100ps
module pioc_ddr_io_sva
(
	input wire logic       i_ref_clk,
	input wire logic       i_rst_n,
	input wire logic       i_pin_c,
	input wire logic       o_pin_a,
	input wire logic       o_pin_a_oe,
	input wire logic       o_pin_c,
	input wire logic       o_pin_c_oe,
	input wire logic [5:0] o_buck_one_vsel,
	input wire logic [5:0] o_buck_two_vsel,
	input wire logic       o_core_rail_reset
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	logic [3:0] fall_age_r;
	// Cycles since pin C fell; saturates so an old fall never looks recent
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			fall_age_r <= 4'hF;
		else if ($fell(i_pin_c))
			fall_age_r <= 4'h0;
		else if (fall_age_r != 4'hF)
			fall_age_r <= fall_age_r + 4'h1;
	end
	property p_pa_od; o_pin_a_oe |-> !o_pin_a; endproperty
	a_pa_od: assert property (p_pa_od) else $error("pin A driven high");
	property p_pc_od; o_pin_c_oe |-> !o_pin_c; endproperty
	a_pc_od: assert property (p_pc_od) else $error("pin C driven high");
	property p_rr_one; o_core_rail_reset |=> !o_core_rail_reset; endproperty
	a_rr_one: assert property (p_rr_one) else $error("rail reset too long");
	property p_rr_fall; o_core_rail_reset |-> fall_age_r inside {[4'h1:4'h8]}; endproperty
	a_rr_fall: assert property (p_rr_fall) else $error("rail reset without fall");
	property p_b1_step;
		$changed(o_buck_one_vsel) |-> (o_buck_one_vsel == $past(o_buck_one_vsel) + 6'h01)
			|| (o_buck_one_vsel == $past(o_buck_one_vsel) - 6'h01);
	endproperty
	a_b1_step: assert property (p_b1_step) else $error("rail one jumped");
	property p_b2_step;
		$changed(o_buck_two_vsel) |-> (o_buck_two_vsel == $past(o_buck_two_vsel) + 6'h01)
			|| (o_buck_two_vsel == $past(o_buck_two_vsel) - 6'h01);
	endproperty
	a_b2_step: assert property (p_b2_step) else $error("rail two jumped");
	property p_b1_hold; $changed(o_buck_one_vsel) |=> $stable(o_buck_one_vsel)[*8]; endproperty
	a_b1_hold: assert property (p_b1_hold) else $error("rail one stepped fast");
	property p_b2_hold; $changed(o_buck_two_vsel) |=> $stable(o_buck_two_vsel)[*8]; endproperty
	a_b2_hold: assert property (p_b2_hold) else $error("rail two stepped fast");
endmodule // pioc_ddr_io_sva

bind pioc_ddr_io pioc_ddr_io_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_pin_c(i_pin_c), .o_pin_a(o_pin_a), .o_pin_a_oe(o_pin_a_oe), .o_pin_c(o_pin_c),
	.o_pin_c_oe(o_pin_c_oe), .o_buck_one_vsel(o_buck_one_vsel),
	.o_buck_two_vsel(o_buck_two_vsel), .o_core_rail_reset(o_core_rail_reset));

//--- bench/pioc_ddr_io_tb.sv
// Self-checking bench of the configurable I/O block.
// Assumes the host model closes the pin loops and the bench is the bus master.
`timescale 1ns/100ps
module pioc_ddr_io_tb;
	localparam logic [7:0] A_CTRL = pioc_pkg::OFS_CTRL;
	localparam logic [7:0] A_B1 = pioc_pkg::OFS_BUCK1;
	logic clk, rst_n, b_rd, b_wr, pg, seq_a, seq_c, host_a, host_c, pa, pc;
	logic pa_oe, pb, pb_oe, pc_oe, wreq, rrst;
	logic [7:0] b_addr;
	logic [31:0] b_wdata, rdata;
	logic [3:0] b_be;
	logic [5:0] v1, v2;
	int err_count, samples_checked;
`define CHK(n, e, a) begin \
	samples_checked++; \
	if ((a) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, a); end \
end
	// Free-running 25 MHz reference
	always #20 clk = ~clk;
	pioc_ddr_io DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_address(b_addr), .i_read(b_rd),
		.i_write(b_wr), .i_writedata(b_wdata), .i_byteenable(b_be), .o_readdata(rdata),
		.o_waitrequest(wreq), .i_pin_a(pa), .o_pin_a(), .o_pin_a_oe(pa_oe), .o_pin_b(pb),
		.o_pin_b_oe(pb_oe), .i_pin_c(pc), .o_pin_c(), .o_pin_c_oe(pc_oe),
		.i_power_good(pg), .i_seq_pin_a_level(seq_a), .i_seq_pin_c_level(seq_c),
		.o_buck_one_vsel(v1), .o_buck_two_vsel(v2), .o_core_rail_reset(rrst));
	pioc_host_model u_host (.i_host_a(host_a), .i_host_c(host_c), .i_pin_a_oe(pa_oe),
		.i_pin_c_oe(pc_oe), .o_pin_a(pa), .o_pin_c(pc));
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Holds the request until waitrequest is seen low, then releases it
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		b_addr <= a;
		b_wdata <= d;
		b_wr <= w;
		b_rd <= !w;
		// No cycle count assumed: only the watchdog ends a wait that never answers
		do
			@(posedge clk);
		while (wreq !== 1'b0);
		q = rdata;
		b_wr <= 1'b0;
		b_rd <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(nm, e, q)
	endtask
	// Bounded wait for the applied rail one code; returns the cycles it took
	task automatic wait_v1(input logic [5:0] e, output int n);
		n = 0;
		while (v1 !== e && n < 4000) begin @(posedge clk); n++; end
		if (v1 !== e)
			err_count++;
	endtask
	task t_reset;
		rchk("ctrl", A_CTRL, 32'h07);
		rchk("buck1", A_B1, 32'h10);
		rchk("buck2", pioc_pkg::OFS_BUCK2, 32'h14);
		`CHK("oe", 3'h0, {pa_oe, pb_oe, pc_oe})
		$display("reset test done");
	endtask
	task t_levels;
		for (int i = 0; i < 4; i++)
		begin
			wr(A_CTRL, {28'h0, i[1], 1'b0, i[0], 1'b0});
			repeat (2) @(posedge clk);
			`CHK("pin_a_oe", 1'b1, pa_oe)
			`CHK("pin_c_oe", 1'b1, pc_oe)
			`CHK("pin_b", {i[1] | !i[0], i[0] & i[1]}, {pb_oe, pb_oe & pb})
		end
		wr(A_CTRL, 32'hC7);
		repeat (2) @(posedge clk);
		`CHK("seq_oe", 2'b11, {pa_oe, pc_oe})
		$display("level test done");
	endtask
	task t_mem_reset;
		wr(A_CTRL, 32'h1F);
		repeat (10) @(posedge clk);
		`CHK("b_por", 2'b10, {pb_oe, pb})
		`CHK("a_input", 1'b0, pa_oe)
		pg <= 1'b1;
		host_a <= 1'b0;
		repeat (10) @(posedge clk);
		`CHK("b_low", 2'b10, {pb_oe, pb})
		host_a <= 1'b1;
		repeat (10) @(posedge clk);
		`CHK("b_high", 2'b11, {pb_oe, pb})
		pg <= 1'b0;
		repeat (10) @(posedge clk);
		host_a <= 1'b0;
		repeat (10) @(posedge clk);
		`CHK("b_held", 2'b11, {pb_oe, pb})
		wr(A_CTRL, 32'h15);
		repeat (2) @(posedge clk);
		`CHK("b_od", 1'b0, pb_oe)
		host_a <= 1'b1;
		pg <= 1'b1;
		$display("memory reset test done");
	endtask
	task t_core_reset;
		logic seen;
		int   n;
		seen = 1'b0;
		wr(pioc_pkg::OFS_SLEW, 32'h1);
		rchk("slew", pioc_pkg::OFS_SLEW, 32'h1);
		wr(pioc_pkg::OFS_BUCK2, 32'h15);
		wr(A_B1, 32'h12);
		// The first step lands at an arbitrary phase, the second a full period later
		wait_v1(6'h11, n);
		wait_v1(6'h12, n);
		`CHK("step", pioc_pkg::SLEW_STEP_CYC << 1, n)
		`CHK("v2_up", 6'h15, v2)
		wr(A_CTRL, 32'h07);
		host_c <= 1'b0;
		repeat (10) @(posedge clk);
		host_c <= 1'b1;
		rchk("gated", A_B1, 32'h12);
		wr(A_CTRL, 32'h27);
		host_c <= 1'b0;
		repeat (20) begin @(posedge clk); seen = seen | rrst; end
		host_c <= 1'b1;
		`CHK("pulse", 1'b1, seen)
		rchk("buck1", A_B1, 32'h10);
		rchk("buck2", pioc_pkg::OFS_BUCK2, 32'h14);
		rchk("ctrl", A_CTRL, 32'h27);
		rchk("slew_kept", pioc_pkg::OFS_SLEW, 32'h1);
		`CHK("ramp", 1'b1, v1 == 6'h12 || v1 == 6'h11)
		wait_v1(6'h10, n);
		`CHK("v1", 6'h10, v1)
		`CHK("v2", 6'h14, v2)
		rchk("count", pioc_pkg::OFS_RSTCNT, 32'h1);
		rchk("status", pioc_pkg::OFS_STATUS, 32'h2F);
		wr(pioc_pkg::OFS_STATUS, 32'h20);
		rchk("cleared", pioc_pkg::OFS_STATUS, 32'h0F);
		$display("core reset test done");
	endtask
	// Stimulus sequence
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		{b_rd, b_wr, pg, seq_a, seq_c} = 5'h0;
		{host_a, host_c} = 2'h3;
		b_addr = 8'h00;
		b_wdata = 32'h0;
		b_be = 4'hF;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_levels;
		t_mem_reset;
		t_core_reset;
		finish_test;
	end
	// Watchdog sized well past the two rail ramps
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test;
	end
endmodule // pioc_ddr_io_tb
